// *** logic/ecf_pkg.sv ***
/*
 ecg sample fifo readout: shared constants, register map and state type.
 assumes a single 25 MHz system clock and a host that talks over the
 serial register port (clock, chip select, data in, data out).
*/
package ecf_pkg;

	// ----------------------------------------------------------------
	// storage geometry
	// ----------------------------------------------------------------
	localparam int ECF_DEPTH   = 32;
	localparam int ECF_WIDTH   = 24;
	localparam int ECF_VOLT_W  = 18;
	localparam int ECF_VOLT_LSB = 6;
	localparam int ECF_TAG_LSB = 3;
	localparam int ECF_CNT_W   = $clog2(ECF_DEPTH) + 1;

	// ----------------------------------------------------------------
	// register map and serial frame
	// ----------------------------------------------------------------
	localparam logic [6:0] ECF_ADDR_BURST  = 7'h20;
	localparam logic [6:0] ECF_ADDR_SINGLE = 7'h21;
	localparam logic [4:0] ECF_CMD_LAST    = 5'h07;
	localparam logic [4:0] ECF_WORD_LAST   = 5'h17;

	// ----------------------------------------------------------------
	// sample tags
	// ----------------------------------------------------------------
	localparam logic [2:0] ECF_TAG_VALID    = 3'h0;
	localparam logic [2:0] ECF_TAG_FAST     = 3'h1;
	localparam logic [2:0] ECF_TAG_EOF      = 3'h2;
	localparam logic [2:0] ECF_TAG_FAST_EOF = 3'h3;
	localparam logic [2:0] ECF_TAG_EMPTY    = 3'h6;
	localparam logic [2:0] ECF_TAG_OVF      = 3'h7;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CMD  = 3'h2,
		ST_DATA = 3'h4
	} ecf_state_t;

endpackage : ecf_pkg

// *** logic/ecf_fifo_if.sv ***
/*
 ecg sample fifo readout: bundle between the serial front end and the
 sample store. assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface ecf_fifo_if;
	import ecf_pkg::*;
	logic                    push;
	logic [ECF_WIDTH-1:0]    pushWord;
	logic                    pop;
	logic                    clear;
	logic [ECF_WIDTH-1:0]    rdWord;
	logic [ECF_CNT_W-1:0]    count;
	logic                    overflow;

	modport store (input push, pushWord, pop, clear, output rdWord, count, overflow);
	modport ctrl  (output push, pushWord, pop, clear, input rdWord, count, overflow);
endinterface : ecf_fifo_if

// *** logic/ecf_fifo_store.sv ***
/*
 ecg sample fifo readout: circular sample store with read and write pointers.
 assumes depth is a power of two so that the pointers wrap on their own.
*/
`timescale 1ns/1ps
module ecf_fifo_store
	import ecf_pkg::*;
#(
	parameter int DEPTH = ECF_DEPTH
)(
	input  wire logic   sys_clk, // system clock
	input  wire logic   rst_n,   // synchronous reset, active low
	ecf_fifo_if.store   fif      // push, pop and status
);

	localparam int AW = $clog2(DEPTH);

	logic [ECF_WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]        wrPtr_ff;
	logic [AW-1:0]        rdPtr_ff;
	logic [ECF_CNT_W-1:0] count_ff;
	logic [ECF_CNT_W-1:0] nxt_count;
	logic                 overflow_ff;
	logic                 full;
	logic                 doPush;
	logic                 doPop;

	assign full   = (count_ff == ECF_CNT_W'(DEPTH));
	// once overflowed the store freezes until cleared
	assign doPush = fif.push && !full && !overflow_ff && !fif.clear;
	// a sample is removed only once and never while empty or corrupted
	assign doPop  = fif.pop && (count_ff != '0) && !overflow_ff && !fif.clear; // [R20]

	assign fif.rdWord   = mem[rdPtr_ff];
	assign fif.count    = count_ff;
	assign fif.overflow = overflow_ff;

	// ----------------------------------------------------------------
	// storage array
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (doPush)
			mem[wrPtr_ff] <= fif.pushWord; // [R18]
	end

	// ----------------------------------------------------------------
	// pointers and fill count
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || fif.clear)
		begin
			wrPtr_ff <= '0; // [R21]
			rdPtr_ff <= '0; // [R21]
		end
		else
		begin
			if (doPush)
				wrPtr_ff <= wrPtr_ff + 1'b1;
			if (doPop)
				rdPtr_ff <= rdPtr_ff + 1'b1;
		end
	end

	always_comb
	begin
		nxt_count = count_ff;
		if (doPush && !doPop)
			nxt_count = count_ff + 1'b1;
		else if (doPop && !doPush)
			nxt_count = count_ff - 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || fif.clear)
			count_ff <= '0; // [R15]
		else
			count_ff <= nxt_count;
	end

	// ----------------------------------------------------------------
	// overflow: write pointer has lapped the read pointer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || fif.clear)
			overflow_ff <= 1'b0; // [R15]
		else if (fif.push && full)
			overflow_ff <= 1'b1; // [R04]
	end

	property p_ovfSet;
		@(posedge sys_clk) disable iff (!rst_n)
		(fif.push && full && !fif.clear) |=> overflow_ff;
	endproperty
	a_ovfSet: assert property (p_ovfSet) else $error("overflow not flagged"); // [R04]

	property p_clearEmpty;
		@(posedge sys_clk) disable iff (!rst_n)
		fif.clear |=> (count_ff == '0) && !overflow_ff && (rdPtr_ff == wrPtr_ff);
	endproperty
	a_clearEmpty: assert property (p_clearEmpty) else $error("clear left data"); // [R21]

	property p_popDrop;
		@(posedge sys_clk) disable iff (!rst_n)
		(doPop && !doPush) |=> (count_ff == $past(count_ff) - 1'b1);
	endproperty
	a_popDrop: assert property (p_popDrop) else $error("pop did not consume"); // [R20]

	property p_countMax;
		@(posedge sys_clk) disable iff (!rst_n)
		(count_ff == ECF_CNT_W'(DEPTH)) && fif.push && !fif.pop && !fif.clear
			|=> count_ff == $past(count_ff);
	endproperty
	a_countMax: assert property (p_countMax) else $error("store grew past depth"); // [R18]

endmodule : ecf_fifo_store

// *** logic/ecf_readout.sv ***
/*
 ecg sample fifo readout: serial register port front end, tag generation,
 fill threshold and clear handling around the circular sample store.
 assumes the serial clock, chip select and data in come from the host in
 another clock domain and are at least four system clocks per half period.
*/
// Function
// [R01] fill threshold selects one to thirty-two entries
// [R02] fill flag rises when unread count reaches threshold
// [R03] host never reads past last stored sample
// [R04] write lapping read pointer raises overflow
// [R05] host clears fifo after any overflow
// [R06] read words: voltage high, tag middle, spare low
// [R07] voltage is eighteen-bit left-justified two's complement
// [R08] tag sits in word bits five to three
// [R09] ordinary sample with more pending tags 000
// [R10] fast-recovery sample tags 001
// [R11] last stored valid sample tags 010
// [R12] last stored fast sample tags 011
// [R13] read of empty fifo tags 110
// [R14] after overflow words tag 111, flag set
// [R15] clear command empties fifo, ends overflow
// [R16] resync realigns timing and resets fifo
// [R17] host waits after end-of-data before reading
// [R18] thirty-two entry circular store, 24-bit words
// [R19] pointer advances at edge 32, then every 24
// [R20] a consumed sample is never returned again
// [R21] reset and clears equalise both pointers
`timescale 1ns/1ps
module ecf_readout
	import ecf_pkg::*;
(
	input  wire logic                  sys_clk,          // system clock
	input  wire logic                  rst_n,            // synchronous reset, active low
	input  wire logic                  sclk,             // serial clock from host
	input  wire logic                  csbN,             // chip select, active low
	input  wire logic                  sdi,              // serial data in
	output logic                       sdo,              // serial data out
	output logic                       sdoOe,            // serial data out enable
	input  wire logic                  sampleValid,      // new conversion, one cycle
	input  wire logic [ECF_VOLT_W-1:0] sampleVoltage,    // conversion voltage
	input  wire logic                  sampleFast,       // taken in fast recovery
	input  wire logic [4:0]            ecgFillThreshold, // unread entries minus one
	input  wire logic                  fifoClearCmd,     // fifo clear pulse
	input  wire logic                  channelResyncCmd, // resync pulse
	output logic                       ecgFillIrqFlag,   // fill threshold reached
	output logic                       ecgOverflowFlag,  // fifo overflowed
	output logic                       resyncPulse,      // realign channel timing
	output logic [ECF_CNT_W-1:0]       ecgUnreadCount    // unread entries
);

	ecf_fifo_if fif ();

	ecf_state_t                state_ff;
	logic       [2:0]          sclkSync_ff;
	logic       [1:0]          csbSync_ff;
	logic       [1:0]          sdiSync_ff;
	logic                      sclkRise;
	logic                      sclkFall;
	logic                      frameOn;
	logic       [4:0]          bitCnt_ff;
	logic       [6:0]          cmd_ff;
	logic       [7:0]          cmdFull;
	logic                      reading_ff;
	logic                      burst_ff;
	logic                      loadReq_ff;
	logic                      loadedValid_ff;
	logic       [ECF_WIDTH-1:0] shift_ff;
	logic                      sdo_ff;
	logic                      sdoOe_ff;
	logic                      fill_ff;
	logic                      resync_ff;
	logic                      wordEnd;
	logic       [10:0]         riseTally_ff;

	// ----------------------------------------------------------------
	// word build: tag is decided when the word is fetched
	// ----------------------------------------------------------------
	function automatic logic [ECF_WIDTH-1:0] makeWord(
		input logic [ECF_WIDTH-1:0] raw,
		input logic [ECF_CNT_W-1:0] cnt,
		input logic                 ovf
	);
		logic [2:0] tag;
		logic [ECF_VOLT_W-1:0] volt;
		tag  = ECF_TAG_VALID; // [R09]
		volt = raw[ECF_WIDTH-1:ECF_VOLT_LSB]; // [R07]
		if (ovf)
			tag = ECF_TAG_OVF; // [R14]
		else if (cnt == '0)
		begin
			tag  = ECF_TAG_EMPTY; // [R13]
			volt = '0;
		end
		else if (cnt == ECF_CNT_W'(1))
			tag = raw[ECF_TAG_LSB] ? ECF_TAG_FAST_EOF : ECF_TAG_EOF; // [R11] [R12]
		else if (raw[ECF_TAG_LSB])
			tag = ECF_TAG_FAST; // [R10]
		return {volt, tag, 3'h0}; // [R06] [R08]
	endfunction : makeWord

	// ----------------------------------------------------------------
	// pin synchronisers and serial clock edges
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			sclkSync_ff <= 3'h0;
			csbSync_ff  <= 2'h3;
			sdiSync_ff  <= 2'h0;
		end
		else
		begin
			sclkSync_ff <= {sclkSync_ff[1:0], sclk};
			csbSync_ff  <= {csbSync_ff[0], csbN};
			sdiSync_ff  <= {sdiSync_ff[0], sdi};
		end
	end

	assign sclkRise = sclkSync_ff[1] && !sclkSync_ff[2];
	assign sclkFall = !sclkSync_ff[1] && sclkSync_ff[2];
	assign frameOn  = !csbSync_ff[1];
	assign cmdFull  = {cmd_ff, sdiSync_ff[1]};
	assign wordEnd  = sclkRise && (state_ff == ST_DATA) && (bitCnt_ff == ECF_WORD_LAST);

	// ----------------------------------------------------------------
	// frame sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !frameOn)
		begin
			state_ff   <= ST_IDLE;
			bitCnt_ff  <= 5'h00;
			cmd_ff     <= 7'h00;
			reading_ff <= 1'b0;
			burst_ff   <= 1'b0;
			loadReq_ff <= 1'b0;
		end
		else
		begin
			loadReq_ff <= 1'b0;
			case (state_ff)
				ST_IDLE:
					state_ff <= ST_CMD;
				ST_CMD:
					if (sclkRise)
					begin
						cmd_ff    <= cmdFull[6:0];
						bitCnt_ff <= bitCnt_ff + 5'h01;
						if (bitCnt_ff == ECF_CMD_LAST)
						begin
							state_ff   <= ST_DATA;
							bitCnt_ff  <= 5'h00;
							reading_ff <= cmdFull[0] && ((cmdFull[7:1] == ECF_ADDR_BURST)
								|| (cmdFull[7:1] == ECF_ADDR_SINGLE));
							burst_ff   <= cmdFull[7:1] == ECF_ADDR_BURST;
							loadReq_ff <= cmdFull[0] && ((cmdFull[7:1] == ECF_ADDR_BURST)
								|| (cmdFull[7:1] == ECF_ADDR_SINGLE));
						end
					end
				ST_DATA:
					if (sclkRise)
					begin
						bitCnt_ff <= (bitCnt_ff == ECF_WORD_LAST) ? 5'h00 : bitCnt_ff + 5'h01;
						if (bitCnt_ff == ECF_WORD_LAST)
						begin
							// a burst refetches after the pop has settled
							loadReq_ff <= reading_ff && burst_ff; // [R19]
							reading_ff <= reading_ff && burst_ff;
						end
					end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read pointer advance at the close of each read word fetched while data was stored and no overflow
	// ----------------------------------------------------------------
	assign fif.pop = wordEnd && reading_ff && loadedValid_ff; // [R19]

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || fif.clear)
			loadedValid_ff <= 1'b0;
		else if (loadReq_ff)
			loadedValid_ff <= (fif.count != '0) && !fif.overflow;
		else if (fif.pop)
			loadedValid_ff <= 1'b0; // [R20]
	end

	// ----------------------------------------------------------------
	// output shifter: data changes on serial clock falling edges
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !frameOn)
		begin
			shift_ff <= '0;
			sdo_ff   <= 1'b0;
			sdoOe_ff <= 1'b0;
		end
		else
		begin
			sdoOe_ff <= (state_ff == ST_DATA) && reading_ff;
			if (loadReq_ff)
				shift_ff <= makeWord(fif.rdWord, fif.count, fif.overflow); // [R06]
			else if (sclkFall && state_ff == ST_DATA)
			begin
				sdo_ff   <= reading_ff && shift_ff[ECF_WIDTH-1];
				shift_ff <= {shift_ff[ECF_WIDTH-2:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// sample entry, clears, status
	// ----------------------------------------------------------------
	assign fif.push     = sampleValid;
	assign fif.pushWord = {sampleVoltage, 2'h0, sampleFast, 3'h0}; // [R07]
	// resync and fifo clear share the pointer reset
	assign fif.clear    = fifoClearCmd || channelResyncCmd; // [R15] [R16]

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			fill_ff   <= 1'b0;
			resync_ff <= 1'b0;
		end
		else
		begin
			fill_ff   <= nxtFill(fif.count, ecgFillThreshold); // [R01] [R02]
			resync_ff <= channelResyncCmd; // [R16]
		end
	end

	function automatic logic nxtFill(
		input logic [ECF_CNT_W-1:0] cnt,
		input logic [4:0]           thr
	);
		return cnt >= ({1'b0, thr} + 6'h01);
	endfunction : nxtFill

	assign sdo             = sdo_ff;
	assign sdoOe           = sdoOe_ff;
	assign ecgFillIrqFlag  = fill_ff;
	assign ecgOverflowFlag = fif.overflow; // [R14]
	assign resyncPulse     = resync_ff;
	assign ecgUnreadCount  = fif.count;

	ecf_fifo_store #(
		.DEPTH (ECF_DEPTH)
	) u_store (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.fif     (fif)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_wordEnd;
		sclkRise && (state_ff == ST_DATA) && (bitCnt_ff == ECF_WORD_LAST);
	endsequence

	sequence s_fetch;
		loadReq_ff && !fif.clear;
	endsequence

	property p_fillFlag;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> fill_ff == ($past(fif.count) >= ({1'b0, $past(ecgFillThreshold)} + 6'h01));
	endproperty
	a_fillFlag: assert property (p_fillFlag) else $error("fill flag mismatch"); // [R02]

	// rising edges seen in this frame, counted apart from the frame sequencer
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !frameOn)
			riseTally_ff <= 11'h000;
		else if (sclkRise)
			riseTally_ff <= riseTally_ff + 11'h001;
	end

	property p_popAt32;
		@(posedge sys_clk) disable iff (!rst_n)
		fif.pop |-> s_wordEnd ##0 ((riseTally_ff >= 11'h01f)
			&& (((riseTally_ff - 11'h01f) % 11'h018) == 11'h000));
	endproperty
	a_popAt32: assert property (p_popAt32) else $error("pop off word boundary"); // [R19]

	property p_emptyTag;
		@(posedge sys_clk) disable iff (!rst_n)
		s_fetch ##0 (fif.count == '0 && !fif.overflow) |=> shift_ff[5:3] == ECF_TAG_EMPTY;
	endproperty
	a_emptyTag: assert property (p_emptyTag) else $error("empty tag missing"); // [R13]

	property p_ovfTag;
		@(posedge sys_clk) disable iff (!rst_n)
		s_fetch ##0 fif.overflow |=> shift_ff[5:3] == ECF_TAG_OVF && ecgOverflowFlag;
	endproperty
	a_ovfTag: assert property (p_ovfTag) else $error("overflow tag missing"); // [R14]

	property p_lastTag;
		@(posedge sys_clk) disable iff (!rst_n)
		s_fetch ##0 (fif.count == ECF_CNT_W'(1) && !fif.overflow)
			|=> shift_ff[5:4] == 2'h1 && shift_ff[3] == $past(fif.rdWord[3]);
	endproperty
	a_lastTag: assert property (p_lastTag) else $error("end tag wrong"); // [R11]

	property p_resync;
		@(posedge sys_clk) disable iff (!rst_n)
		channelResyncCmd |=> resyncPulse && ecgUnreadCount == '0 && !ecgOverflowFlag;
	endproperty
	a_resync: assert property (p_resync) else $error("resync did not reset fifo"); // [R16]

endmodule : ecf_readout

// *** tb/ecf_host_model.sv ***
/*
 host side of the ecg sample fifo readout: a behavioural serial master that
 frames fifo reads and captures the returned words.
 assumes the device sees sclk through a synchroniser on the 25 MHz clock;
 one sclk half period is four system clocks (320 ns period).
*/
`timescale 1ns/1ps
module ecf_host_model (
	input  wire logic sysClk, // system clock, paces the serial clock
	output logic      sclk,   // serial clock, idles low
	output logic      csbN,   // chip select, active low
	output logic      sdi,    // serial data to device
	input  wire logic sdo,    // serial data from device
	input  wire logic sdoOe   // device drives sdo
);
	logic [23:0] rxWord [0:3];
	logic        oeSeen;

	initial
	begin
		sclk = 1'b0;
		csbN = 1'b1;
		sdi = 1'b1;
		oeSeen = 1'b0;
	end

	task half();
		repeat (4) @(posedge sysClk);
		#1;
	endtask : half

	// ----------------------------------------------------------------
	// one frame: 8 header bits, then 24 bits per word
	// ----------------------------------------------------------------
	// callers ask only for stored words, except where an empty read is meant
	task frame(input logic [6:0] addr, input logic rdBit, input int nWords);
		logic [7:0] hdr;
		int         k;
		hdr = {addr, rdBit};
		oeSeen = 1'b0;
		csbN = 1'b0;
		half();
		for (k = 0; k < 8 + 24 * nWords; k++)
		begin
			// data phase sdi is don't care, so it toggles rather than holding
			sdi = (k < 8) ? hdr[7-k] : ~sdi;
			half();
			sclk = 1'b1;
			repeat (2) @(posedge sysClk);
			#1;
			// sampled mid high phase: sdo only moves after a falling edge
			if (k >= 8)
				rxWord[(k-8)/24][23-((k-8)%24)] = sdo;
			oeSeen = oeSeen | sdoOe;
			repeat (2) @(posedge sysClk);
			#1;
			sclk = 1'b0;
		end
		half();
		csbN = 1'b1;
		sdi = ~sdi;
		half();
		half();
	endtask : frame
endmodule : ecf_host_model

// *** tb/tb_top.sv ***
/*
 self-checking bench for the ecg sample fifo readout.
 assumes the host model paces its own frames; all bench stimulus moves
 1 ns after a rising system clock edge.
*/
`timescale 1ns/1ps
module tb_top;
	import ecf_pkg::*;
	logic                 sysClk;
	logic                 rstN;
	logic                 sclk;
	logic                 csbN;
	logic                 sdi;
	logic                 sdo;
	logic                 sdoOe;
	logic                 sampleValid;
	logic [ECF_VOLT_W-1:0] sampleVoltage;
	logic                 sampleFast;
	logic [4:0]           ecgFillThreshold;
	logic                 fifoClearCmd;
	logic                 channelResyncCmd;
	logic                 ecgFillIrqFlag;
	logic                 ecgOverflowFlag;
	logic                 resyncPulse;
	logic [ECF_CNT_W-1:0] ecgUnreadCount;
	int                   errors;
	int                   checkCount;
	int                   cycles;

	ecf_readout dut (
		.sys_clk(sysClk), .rst_n(rstN), .sclk(sclk), .csbN(csbN), .sdi(sdi),
		.sdo(sdo), .sdoOe(sdoOe), .sampleValid(sampleValid),
		.sampleVoltage(sampleVoltage), .sampleFast(sampleFast),
		.ecgFillThreshold(ecgFillThreshold), .fifoClearCmd(fifoClearCmd),
		.channelResyncCmd(channelResyncCmd), .ecgFillIrqFlag(ecgFillIrqFlag),
		.ecgOverflowFlag(ecgOverflowFlag), .resyncPulse(resyncPulse),
		.ecgUnreadCount(ecgUnreadCount)
	);

	ecf_host_model host (
		.sysClk(sysClk), .sclk(sclk), .csbN(csbN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe)
	);

	initial
	begin
		sysClk = 1'b0;
		forever #20 sysClk = ~sysClk;
	end

	// ----------------------------------------------------------------
	// compare, report and pacing helpers
	// ----------------------------------------------------------------
	task close_out();
		$display("checks %0d mismatches %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	// the run needs about 3000 cycles; the ceiling leaves ample margin
	always @(posedge sysClk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			errors++;
			$display("[ERR] run time expected under 30000 seen 30000");
			close_out();
		end
	end

	task chk_vec(input string name, input logic [23:0] exp, input logic [23:0] got);
		checkCount++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_vec

	task chk_bit(input string name, input logic exp, input logic got);
		checkCount++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %b seen %b", name, exp, got);
		end
	endtask : chk_bit

	task tick(input int n);
		repeat (n) @(posedge sysClk);
		#1;
	endtask : tick

	task push(input logic [17:0] volt, input logic fast, input int n);
		int i;
		tick(1);
		for (i = 0; i < n; i++)
		begin
			sampleValid = 1'b1;
			sampleVoltage = volt + 18'(i);
			sampleFast = fast;
			tick(1);
		end
		sampleValid = 1'b0;
		tick(2);
	endtask : push

	task chk_word(input int idx, input logic [17:0] volt, input logic [2:0] tag);
		chk_vec("fifo word", {volt, tag, 3'h0}, {host.rxWord[idx][23:3], 3'h0});
	endtask : chk_word

	task chk_cnt(input logic [5:0] exp);
		chk_vec("unread count", {18'h0, exp}, {18'h0, ecgUnreadCount});
	endtask : chk_cnt

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task sc_reset();
		chk_cnt(6'h0);
		chk_bit("overflow flag", 1'b0, ecgOverflowFlag);
		chk_bit("fill flag", 1'b0, ecgFillIrqFlag);
		chk_bit("sdo enable", 1'b0, sdoOe);
	endtask : sc_reset

	task sc_empty_read();
		host.frame(ECF_ADDR_SINGLE, 1'b1, 1);
		chk_word(0, 18'h0, ECF_TAG_EMPTY);
		chk_bit("sdo enable seen", 1'b1, host.oeSeen);
		chk_cnt(6'h0);
	endtask : sc_empty_read

	task sc_fill_and_tags();
		ecgFillThreshold = 5'h02;
		push(18'h2a5c1, 1'b0, 1);
		push(18'h15a3e, 1'b1, 1);
		push(18'h3ffff, 1'b0, 1);
		chk_cnt(6'h3);
		chk_bit("fill flag", 1'b1, ecgFillIrqFlag);
		host.frame(ECF_ADDR_SINGLE, 1'b1, 1);
		chk_word(0, 18'h2a5c1, ECF_TAG_VALID);
		tick(2);
		chk_cnt(6'h2);
		chk_bit("fill flag", 1'b0, ecgFillIrqFlag);
		host.frame(ECF_ADDR_BURST, 1'b1, 2);
		chk_word(0, 18'h15a3e, ECF_TAG_FAST);
		chk_word(1, 18'h3ffff, ECF_TAG_EOF);
		tick(2);
		chk_cnt(6'h0);
		host.frame(ECF_ADDR_SINGLE, 1'b1, 1);
		chk_word(0, 18'h0, ECF_TAG_EMPTY);
	endtask : sc_fill_and_tags

	task sc_last_fast();
		ecgFillThreshold = 5'h00;
		push(18'h20040, 1'b1, 1);
		chk_bit("fill flag", 1'b1, ecgFillIrqFlag);
		host.frame(ECF_ADDR_SINGLE, 1'b1, 1);
		chk_word(0, 18'h20040, ECF_TAG_FAST_EOF);
	endtask : sc_last_fast

	task sc_overflow();
		ecgFillThreshold = 5'h1f;
		push(18'h01000, 1'b0, 31);
		chk_bit("fill flag", 1'b0, ecgFillIrqFlag);
		push(18'h01100, 1'b0, 1);
		chk_bit("fill flag", 1'b1, ecgFillIrqFlag);
		chk_cnt(6'h20);
		chk_bit("overflow flag", 1'b0, ecgOverflowFlag);
		push(18'h01200, 1'b0, 1);
		chk_bit("overflow flag", 1'b1, ecgOverflowFlag);
		host.frame(ECF_ADDR_SINGLE, 1'b1, 1);
		chk_vec("tag", {21'h0, ECF_TAG_OVF}, {21'h0, host.rxWord[0][5:3]});
		chk_cnt(6'h20);
		// the host clears before sampling resumes
		fifoClearCmd = 1'b1;
		tick(1);
		fifoClearCmd = 1'b0;
		tick(1);
		chk_cnt(6'h0);
		chk_bit("overflow flag", 1'b0, ecgOverflowFlag);
		push(18'h00777, 1'b0, 1);
		host.frame(ECF_ADDR_SINGLE, 1'b1, 1);
		chk_word(0, 18'h00777, ECF_TAG_EOF);
	endtask : sc_overflow

	task sc_resync();
		push(18'h12345, 1'b0, 2);
		chk_cnt(6'h2);
		channelResyncCmd = 1'b1;
		tick(1);
		channelResyncCmd = 1'b0;
		chk_bit("resync pulse", 1'b1, resyncPulse);
		tick(1);
		chk_bit("resync pulse", 1'b0, resyncPulse);
		chk_cnt(6'h0);
	endtask : sc_resync

	task sc_refused();
		push(18'h0abcd, 1'b0, 1);
		host.frame(7'h22, 1'b1, 1);
		chk_bit("sdo enable seen", 1'b0, host.oeSeen);
		host.frame(ECF_ADDR_SINGLE, 1'b0, 1);
		chk_bit("sdo enable seen", 1'b0, host.oeSeen);
		chk_cnt(6'h1);
	endtask : sc_refused

	// reset in mid-run must drop whatever is still stored
	task sc_mid_reset();
		push(18'h05555, 1'b0, 2);
		chk_cnt(6'h3);
		rstN = 1'b0;
		tick(4);
		rstN = 1'b1;
		tick(3);
		chk_cnt(6'h0);
		chk_bit("fill flag", 1'b0, ecgFillIrqFlag);
		chk_bit("overflow flag", 1'b0, ecgOverflowFlag);
		host.frame(ECF_ADDR_SINGLE, 1'b1, 1);
		chk_word(0, 18'h0, ECF_TAG_EMPTY);
	endtask : sc_mid_reset

	initial
	begin
		errors = 0;
		checkCount = 0;
		cycles = 0;
		rstN = 1'b0;
		sampleValid = 1'b0;
		sampleVoltage = 18'h0;
		sampleFast = 1'b0;
		ecgFillThreshold = 5'h00;
		fifoClearCmd = 1'b0;
		channelResyncCmd = 1'b0;
		tick(6);
		rstN = 1'b1;
		tick(3);
		sc_reset();
		sc_empty_read();
		sc_fill_and_tags();
		sc_last_fast();
		sc_overflow();
		sc_resync();
		sc_refused();
		sc_mid_reset();
		close_out();
	end
endmodule : tb_top
